// [design/apm_pkg.sv]
// types shared by the axis position monitor
// assumes apm_regs.svh for the numeric constants
package apm_pkg;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_APPR = 2'b10} apm_state_t;
	typedef enum logic [2:0] {LEN_OFF = 3'b000, LEN_RR = 3'b001, LEN_FF = 3'b010,
		LEN_RF = 3'b011, LEN_FR = 3'b100} apm_len_t;
	typedef struct packed {
		apm_len_t len_mode;
		logic     ref_minus;
		logic     wr_en;
		logic     win_en;
		logic     appr_en;
		logic     prog_en;
		logic     cnt_inv;
		logic     rotary;
		logic     unipolar;
	} apm_cfg_t;
	typedef struct packed {
		logic ref_arm;
		logic cancel;
		logic dir_minus;
		logic start;
		logic run;
	} apm_ctrl_t;
	typedef struct packed {
		logic len_done;
		logic win_err;
		logic appr_err;
		logic prog_err;
		logic wr_err;
		logic tr_err;
		logic meas_act;
		logic pos_rcd;
		logic sync;
		logic working;
	} apm_stat_t;
endpackage

// [design/apm_regs.svh]
// register map, reset values and timing constants of the axis position monitor
// assumes an AXI4-Lite slave with 32-bit data and byte addresses
`ifndef APM_REGS_SVH
`define APM_REGS_SVH
`define APM_AW          8
`define APM_OFS_CTRL    8'h00
`define APM_OFS_CFG     8'h04
`define APM_OFS_SUPV    8'h08
`define APM_OFS_LOW     8'h0c
`define APM_OFS_HIGH    8'h10
`define APM_OFS_ROTEND  8'h14
`define APM_OFS_REF     8'h18
`define APM_OFS_TGT     8'h1c
`define APM_OFS_TRANGE  8'h20
`define APM_OFS_CUTOFF  8'h24
`define APM_OFS_SPEED   8'h28
`define APM_OFS_STAT    8'h2c
`define APM_OFS_POS     8'h30
`define APM_OFS_LEN     8'h34
`define APM_OFS_INCREV  8'h38
`define APM_RST_CFG     11'h048
`define APM_RST_SUPV    32'h000007d0
`define APM_RST_LOW     32'hfa0a1f00
`define APM_RST_HIGH    32'h05f5e100
`define APM_RST_ROTEND  32'h000186a0
`define APM_RST_REF     32'h00000000
`define APM_RST_TRANGE  32'h00000032
`define APM_RST_CUTOFF  32'h0000000a
`define APM_RST_SPEED   15'h1000
`define APM_RST_INCREV  32'h000003e8
`define APM_TRAV_MAX    32'h1dcd6500
`define APM_STEP_MS     32'h00000004
`define APM_STEP_NS     4000000
`define APM_CLK_NS      4
`define APM_TICK_CYC    (`APM_STEP_NS / `APM_CLK_NS)
`define APM_RESP_OK     2'b00
`define APM_RESP_ERR    2'b10
`endif

// [design/apm_top.sv]
// axis position monitor: encoder count, supervision and setpoint sign
// assumes encoder and switch inputs already synchronous to aclk
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "apm_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module apm_top
	import apm_pkg::*;
#(
	parameter int TICK_CYC = `APM_TICK_CYC
)(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [`APM_AW-1:0]  s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [`APM_AW-1:0]  s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                enc_a,
	input  wire logic                enc_b,
	input  wire logic                ref_sw,
	input  wire logic                meas_in,
	output logic signed [15:0]       setpoint,
	output logic                     direction_output,
	output logic                     drive_enable,
	output logic                     ext_error
);
	if (TICK_CYC < 1) begin : g_chk
		$error("TICK_CYC must be at least one");
	end

	// bus slave state
	logic              aw_full_reg, w_full_reg;
	logic [`APM_AW-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	// configuration
	apm_cfg_t          cfg_reg;
	logic              run_reg;
	logic [31:0]       supv_reg, low_reg, high_reg, end_reg, ref_reg;
	logic [31:0]       tgt_reg, trng_reg, cut_reg, inc_reg;
	logic [14:0]       spd_reg;
	// axis state
	apm_state_t        st_reg, st_next;
	logic signed [31:0] pos_reg, pos_next, len_reg, mstart_reg;
	logic              sync_reg, dirm_reg, rcd_reg, rcd_arm_reg, win_arm_reg;
	logic              ref_arm_reg, mv_up_reg, meas_act_reg;
	logic              a_q, b_q, ref_q, meas_q;
	logic [31:0]       tick_reg, sup_reg;
	logic              tr_err_reg, wr_err_reg, prog_err_reg, appr_err_reg, len_done_reg;

	// write decode; byte enables merge into the old word
	wire        do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire [31:0] wmask;
	for (genvar i = 0; i < 4; i++) begin : g_strb
		assign wmask[8*i +: 8] = {8{wstrb_reg[i]}};
	end
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction
	wire wr_ctrl  = do_wr && waddr_reg == `APM_OFS_CTRL;
	wire wr_stat  = do_wr && waddr_reg == `APM_OFS_STAT;
	wire wr_hit   = waddr_reg == `APM_OFS_CTRL || waddr_reg == `APM_OFS_CFG ||
		waddr_reg == `APM_OFS_SUPV || waddr_reg == `APM_OFS_LOW ||
		waddr_reg == `APM_OFS_HIGH || waddr_reg == `APM_OFS_ROTEND ||
		waddr_reg == `APM_OFS_REF || waddr_reg == `APM_OFS_TGT ||
		waddr_reg == `APM_OFS_TRANGE || waddr_reg == `APM_OFS_CUTOFF ||
		waddr_reg == `APM_OFS_SPEED || waddr_reg == `APM_OFS_STAT ||
		waddr_reg == `APM_OFS_INCREV;
	wire apm_ctrl_t cmd = apm_ctrl_t'(wdata_reg[$bits(apm_ctrl_t)-1:0]);
	wire apm_stat_t clr = apm_stat_t'(wdata_reg[$bits(apm_stat_t)-1:0] & wmask[$bits(apm_stat_t)-1:0]);
	wire run_rise  = wr_ctrl && wstrb_reg[0] && cmd.run && !run_reg;
	wire start_cmd = wr_ctrl && wstrb_reg[0] && cmd.start && (run_reg || cmd.run);
	wire cancel    = wr_ctrl && wstrb_reg[0] && cmd.cancel;

	// quadrature decode: exactly one phase changed means a valid edge
	wire q_edge  = (enc_a ^ a_q) ^ (enc_b ^ b_q);
	wire q_up    = enc_a ^ b_q;
	wire pos_inc = q_edge && (q_up ^ cfg_reg.cnt_inv);
	wire pos_dec = q_edge && !(q_up ^ cfg_reg.cnt_inv);

	// reference approach ends on leaving the switch toward the chosen side
	wire ref_done = ref_arm_reg && ref_q && !ref_sw && (mv_up_reg != cfg_reg.ref_minus);
	wire ref_load = run_rise || ref_done;

	// window, cut-off and limit checks
	wire signed [31:0] tgt_s  = tgt_reg;
	wire signed [31:0] end_s  = end_reg;
	wire signed [32:0] dpos   = 33'(pos_reg) - 33'(tgt_s);
	wire signed [32:0] half   = 33'((trng_reg + 32'h1) >> 1);     // odd ranges round up
	wire        in_win  = dpos <= half && -dpos <= half;
	wire        cut_hit = dirm_reg ? (pos_reg <= tgt_s + $signed(cut_reg))
	                               : (pos_reg >= tgt_s - $signed(cut_reg));
	wire        trav_bad = pos_reg > $signed(`APM_TRAV_MAX) || pos_reg < -$signed(`APM_TRAV_MAX);
	wire        wr_bad  = !cfg_reg.rotary && sync_reg && cfg_reg.wr_en &&
		(pos_reg < $signed(low_reg) || pos_reg > $signed(high_reg));

	// supervision: 4 ms ticks, time rounded up to whole steps
	wire [31:0] sup_lim  = (supv_reg + `APM_STEP_MS - 32'h1) / `APM_STEP_MS;
	wire        sup_on   = sup_lim != 32'h0;
	wire        tick     = tick_reg == 32'(TICK_CYC - 1);
	wire        progress = dirm_reg ? pos_dec : pos_inc;
	wire        sup_out  = sup_on && sup_reg >= sup_lim;
	wire prog_trip = st_reg == ST_RUN && cfg_reg.prog_en && sup_out;
	wire appr_trip = st_reg == ST_APPR && cfg_reg.appr_en && sup_out && !in_win;
	wire abort     = trav_bad || wr_bad || prog_trip || cancel;

	// run sequencing
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: if (start_cmd) begin
				st_next = ST_RUN;
			end
			ST_RUN: if (cut_hit) begin
				st_next = ST_APPR;
			end
			ST_APPR: if (!cfg_reg.appr_en || !sup_on || in_win || appr_trip) begin
				st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
		if (abort) begin
			st_next = ST_IDLE;
		end
	end

	// position: rotary wraps, linear counts freely
	always_comb begin
		pos_next = pos_reg;
		if (ref_load) begin
			pos_next = $signed(ref_reg);
		end else if (pos_inc) begin
			pos_next = (cfg_reg.rotary && pos_reg >= end_s - 32'sd1) ? 32'sd0 : pos_reg + 32'sd1;
		end else if (pos_dec) begin
			pos_next = (cfg_reg.rotary && pos_reg <= 32'sd0) ? end_s - 32'sd1 : pos_reg - 32'sd1;
		end
	end

	// length measurement edge selection
	wire m_rise = meas_in && !meas_q;
	wire m_fall = !meas_in && meas_q;
	wire m_start = (cfg_reg.len_mode == LEN_RR || cfg_reg.len_mode == LEN_RF) ? m_rise :
		(cfg_reg.len_mode == LEN_FF || cfg_reg.len_mode == LEN_FR) ? m_fall : 1'b0;
	wire m_stop = (cfg_reg.len_mode == LEN_RR || cfg_reg.len_mode == LEN_FR) ? m_rise :
		(cfg_reg.len_mode == LEN_FF || cfg_reg.len_mode == LEN_RF) ? m_fall : 1'b0;

	wire signed [15:0] spd_s = {1'b0, spd_reg};
	wire apm_stat_t stat = '{len_done: len_done_reg, win_err: ext_error, appr_err: appr_err_reg,
		prog_err: prog_err_reg, wr_err: wr_err_reg, tr_err: tr_err_reg, meas_act: meas_act_reg,
		pos_rcd: rcd_reg, sync: sync_reg, working: st_reg == ST_RUN};

	// read mux; unmapped reads return zero with an error response
	wire [31:0] rd_mux =
		s_axi_araddr == `APM_OFS_CTRL   ? 32'(run_reg) :
		s_axi_araddr == `APM_OFS_CFG    ? 32'(cfg_reg) :
		s_axi_araddr == `APM_OFS_SUPV   ? supv_reg :
		s_axi_araddr == `APM_OFS_LOW    ? low_reg :
		s_axi_araddr == `APM_OFS_HIGH   ? high_reg :
		s_axi_araddr == `APM_OFS_ROTEND ? end_reg :
		s_axi_araddr == `APM_OFS_REF    ? ref_reg :
		s_axi_araddr == `APM_OFS_TGT    ? tgt_reg :
		s_axi_araddr == `APM_OFS_TRANGE ? trng_reg :
		s_axi_araddr == `APM_OFS_CUTOFF ? cut_reg :
		s_axi_araddr == `APM_OFS_SPEED  ? 32'(spd_reg) :
		s_axi_araddr == `APM_OFS_STAT   ? 32'(stat) :
		s_axi_araddr == `APM_OFS_POS    ? pos_reg :
		s_axi_araddr == `APM_OFS_LEN    ? len_reg :
		s_axi_araddr == `APM_OFS_INCREV ? inc_reg : 32'h0;
	wire rd_hit = rd_mux != 32'h0 || s_axi_araddr <= `APM_OFS_INCREV && s_axi_araddr[1:0] == 2'b00;

	// bus handshakes: one write and one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_bresp   <= `APM_RESP_OK;
			s_axi_rresp   <= `APM_RESP_OK;
			s_axi_rdata   <= 32'h0;
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			waddr_reg     <= '0;
			wdata_reg     <= 32'h0;
			wstrb_reg     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_full_reg   <= 1'b1;
				waddr_reg     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_full_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `APM_RESP_OK : `APM_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_hit ? `APM_RESP_OK : `APM_RESP_ERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// configuration registers, static between runs by convention
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg  <= apm_cfg_t'(`APM_RST_CFG);             // progress and working range on
			run_reg  <= 1'b0;
			supv_reg <= `APM_RST_SUPV;
			low_reg  <= `APM_RST_LOW;
			high_reg <= `APM_RST_HIGH;
			end_reg  <= `APM_RST_ROTEND;
			ref_reg  <= `APM_RST_REF;
			tgt_reg  <= 32'h0;
			trng_reg <= `APM_RST_TRANGE;
			cut_reg  <= `APM_RST_CUTOFF;
			spd_reg  <= `APM_RST_SPEED;
			inc_reg  <= `APM_RST_INCREV;
		end else if (do_wr) begin
			if (wr_ctrl && wstrb_reg[0]) run_reg <= cmd.run;
			if (waddr_reg == `APM_OFS_CFG) cfg_reg <= apm_cfg_t'(merge(32'(cfg_reg), wdata_reg, wmask));
			if (waddr_reg == `APM_OFS_SUPV) supv_reg <= merge(supv_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_LOW) low_reg <= merge(low_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_HIGH) high_reg <= merge(high_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_ROTEND) end_reg <= merge(end_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_REF) ref_reg <= merge(ref_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_TGT) tgt_reg <= merge(tgt_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_TRANGE) trng_reg <= merge(trng_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_CUTOFF) cut_reg <= merge(cut_reg, wdata_reg, wmask);
			if (waddr_reg == `APM_OFS_SPEED) spd_reg <= 15'(merge(32'(spd_reg), wdata_reg, wmask));
			if (waddr_reg == `APM_OFS_INCREV) inc_reg <= merge(inc_reg, wdata_reg, wmask);
		end
	end

	// axis state, supervision and drive outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= ST_IDLE;
			pos_reg <= 32'sd0;
			{a_q, b_q, ref_q, meas_q} <= 4'h0;
			{sync_reg, dirm_reg, rcd_reg, rcd_arm_reg, win_arm_reg, ref_arm_reg, mv_up_reg} <= 7'h0;
			{tr_err_reg, wr_err_reg, prog_err_reg, appr_err_reg, len_done_reg, ext_error} <= 6'h0;
			{meas_act_reg, drive_enable, direction_output} <= 3'h0;
			tick_reg <= 32'h0;
			sup_reg <= 32'h0;
			len_reg <= 32'sd0;
			mstart_reg <= 32'sd0;
			setpoint <= 16'sh0;
		end else begin
			{a_q, b_q, ref_q, meas_q} <= {enc_a, enc_b, ref_sw, meas_in};
			st_reg  <= st_next;
			pos_reg <= pos_next;
			if (pos_inc || pos_dec) mv_up_reg <= pos_inc;
			tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
			// restart the interval on any state change or on a forward pulse while running
			if (st_next != st_reg || (st_reg == ST_RUN && progress)) sup_reg <= 32'h0;
			else if (tick && !sup_out) sup_reg <= sup_reg + 32'h1;
			if (start_cmd && st_reg == ST_IDLE && !abort) begin
				dirm_reg    <= cmd.dir_minus;
				rcd_reg     <= 1'b0;
				rcd_arm_reg <= 1'b1;
				win_arm_reg <= 1'b0;                          // cleared; re-armed once the axis reaches the window after the run
			end else if (st_reg != ST_RUN && rcd_arm_reg && in_win) begin
				rcd_reg     <= 1'b1;
				rcd_arm_reg <= 1'b0;
				win_arm_reg <= cfg_reg.win_en;
			end else if (win_arm_reg && !in_win) begin
				win_arm_reg <= 1'b0;
			end
			if (wr_ctrl && wstrb_reg[0] && cmd.ref_arm) ref_arm_reg <= 1'b1;
			else if (ref_done) ref_arm_reg <= 1'b0;
			// sync: set by reference, cleared by stop-to-run or range trip
			if (run_rise || trav_bad) sync_reg <= 1'b0;
			else if (ref_done) sync_reg <= 1'b1;
			// sticky errors: a new event wins over a write-one clear
			tr_err_reg   <= trav_bad  || (tr_err_reg   && !(wr_stat && clr.tr_err));
			wr_err_reg   <= wr_bad    || (wr_err_reg   && !(wr_stat && clr.wr_err));
			prog_err_reg <= prog_trip || (prog_err_reg && !(wr_stat && clr.prog_err));
			appr_err_reg <= appr_trip || (appr_err_reg && !(wr_stat && clr.appr_err));
			ext_error    <= (win_arm_reg && !in_win) || (ext_error && !(wr_stat && clr.win_err));
			// length measurement; a stop edge takes priority while active
			if (meas_act_reg && m_stop) begin
				len_reg      <= pos_reg - mstart_reg;
				meas_act_reg <= 1'b0;
			end else if (!meas_act_reg && m_start) begin
				mstart_reg   <= pos_reg;
				meas_act_reg <= 1'b1;
			end
			len_done_reg <= (meas_act_reg && m_stop) || (len_done_reg && !(wr_stat && clr.len_done));
			// converter outputs follow the next state
			drive_enable <= st_next == ST_RUN;
			if (st_next != ST_RUN) setpoint <= 16'sh0;
			else if (cfg_reg.unipolar) setpoint <= spd_s;
			else setpoint <= (start_cmd && st_reg == ST_IDLE ? cmd.dir_minus : dirm_reg) ? -spd_s : spd_s;
			if (st_next == ST_RUN && cfg_reg.unipolar) // held between runs to avoid direction chatter
				direction_output <= start_cmd && st_reg == ST_IDLE ? cmd.dir_minus : dirm_reg;
			else if (!cfg_reg.unipolar) direction_output <= 1'b0;
		end
	end

	bipolar_sign_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg == ST_RUN && st_next == ST_RUN && !cfg_reg.unipolar) |=>
		setpoint == ($past(dirm_reg) ? -$past(spd_s) : $past(spd_s)))
		else $error("bipolar setpoint sign wrong");
	unipolar_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg == ST_RUN && st_next == ST_RUN && cfg_reg.unipolar) |=>
		direction_output == $past(dirm_reg) && setpoint == $past(spd_s))
		else $error("unipolar direction or setpoint wrong");
	prog_cancel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prog_trip |=> st_reg == ST_IDLE && !drive_enable && prog_err_reg)
		else $error("progress trip did not cancel run");
	sup_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		supv_reg == 32'h0 |-> !prog_trip && !appr_trip)
		else $error("supervision active with zero time");
	rotary_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_reg.rotary && pos_reg == end_s - 32'sd1 && pos_inc && !ref_load) |=> pos_reg == 32'sd0)
		else $error("rotary upward wrap wrong");
	rotary_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_reg.rotary && pos_reg == 32'sd0 && pos_dec && !ref_load) |=> pos_reg == $past(end_s) - 32'sd1)
		else $error("rotary downward wrap wrong");
	sync_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		run_rise |=> !sync_reg ##1 (!sync_reg || $past(ref_done)))
		else $error("sync kept over stop-to-run");
	ref_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_load |=> pos_reg == $signed($past(ref_reg)))
		else $error("reference coordinate not loaded");
	trav_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
		trav_bad |=> !sync_reg && st_reg == ST_IDLE && tr_err_reg)
		else $error("traversing range trip not handled");
	limit_cancel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_bad && st_reg == ST_RUN) |=> st_reg == ST_IDLE && wr_err_reg)
		else $error("soft limit violation did not cancel");
endmodule
`default_nettype wire

// [testbench/apm_drive_model.sv]
// drive plus quadrature encoder seen by the axis position monitor
// assumes the direction comes from setpoint sign, or direction_output in unipolar mode
`timescale 1ns/100ps
`default_nettype none
module apm_drive_model #(
	parameter int STEP_CYC = 3
)(
	input  wire logic               aclk,
	input  wire logic signed [15:0] setpoint,
	input  wire logic               direction_output,
	input  wire logic               drive_enable,
	input  wire logic               unipolar,
	input  wire logic               stall,
	output logic                    enc_a,
	output logic                    enc_b
);
	logic [1:0] phase_reg = 2'b00;
	int         div_reg   = 0;
	wire logic  minus     = unipolar ? direction_output : setpoint[15];
	// one quadrature step per STEP_CYC cycles; stall models a jammed axis
	always_ff @(posedge aclk) begin
		div_reg <= (div_reg == STEP_CYC - 1) ? 0 : div_reg + 1;
		if (drive_enable && !stall && setpoint != 16'sh0000 && div_reg == 0)
			phase_reg <= minus ? phase_reg - 2'h1 : phase_reg + 2'h1;
	end
	// gray order a leads b when moving up
	assign enc_a = phase_reg[1] ^ phase_reg[0];
	assign enc_b = phase_reg[1];
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the axis position monitor
// assumes apm_top, apm_drive_model and apm_regs.svh on the include path
`include "apm_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic               aclk = 0, aresetn = 0, ref_sw = 0, meas_in = 0, uni = 0, stall = 0;
	logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0]        s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0]         s_axi_wstrb = 4'hf;
	logic [1:0]         s_axi_bresp, s_axi_rresp, rr;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic               enc_a, enc_b, direction_output, drive_enable, ext_error;
	logic signed [15:0] setpoint;
	int                 err_total = 0, comparisons = 0;
	apm_top #(.TICK_CYC(5)) apm_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .enc_a(enc_a), .enc_b(enc_b),
		.ref_sw(ref_sw), .meas_in(meas_in), .setpoint(setpoint), .direction_output(direction_output),
		.drive_enable(drive_enable), .ext_error(ext_error));
	apm_drive_model apm_drive_model_inst (.aclk, .setpoint, .direction_output, .drive_enable,
		.unipolar(uni), .stall, .enc_a, .enc_b);
	initial forever #2 aclk = ~aclk;
	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok = 0, w_ok = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			aw_ok = aw_ok | s_axi_awready;
			w_ok = w_ok | s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk); // spare edge: a following call never re-raises bready in the same step
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk); // spare edge: a following call never re-raises rready in the same step
	endtask
	// start a run, then look once the start has landed
	task automatic go(input logic [31:0] c);
		wr(`APM_OFS_CTRL, c);
		@(posedge aclk);
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 3000 && drive_enable; n++)
			@(posedge aclk);
	endtask
	task automatic t_defaults();
		rd(`APM_OFS_CFG);
		`CHK(rv, 32'h00000048)
		rd(`APM_OFS_ROTEND);
		`CHK(rv, 32'h000186a0)
		rd(`APM_OFS_LOW);
		`CHK(rv, 32'hfa0a1f00)
		rd(8'h3c);
		`CHK({rr, rv}, 34'h200000000)
		wr(8'h3c, 32'h0);
		`CHK(rr, 2'b10)
	endtask
	task automatic t_bipolar();
		wr(`APM_OFS_SUPV, 32'h8);
		wr(`APM_OFS_REF, 32'h5);
		wr(`APM_OFS_TGT, 32'h64);
		wr(`APM_OFS_CTRL, 32'h1);
		rd(`APM_OFS_POS);
		`CHK(rv, 32'h5)
		rd(`APM_OFS_STAT);
		`CHK(rv[1], 1'b0)
		go(32'h3);
		`CHK({setpoint > 0, direction_output}, 2'b10)
		wait_idle();
		rd(`APM_OFS_POS);
		`CHK($signed(rv) >= 90 && $signed(rv) < 100, 1'b1)
		rd(`APM_OFS_STAT);
		`CHK(rv[6], 1'b0)
		wr(`APM_OFS_TGT, 32'h0);
		go(32'h7);
		`CHK(setpoint < 0, 1'b1)
		wait_idle();
		rd(`APM_OFS_POS);
		`CHK($signed(rv) <= 10, 1'b1)
	endtask
	task automatic t_unipolar();
		wr(`APM_OFS_CFG, 32'h49);
		uni <= 1'b1;
		wr(`APM_OFS_TGT, 32'hffffff38);
		go(32'h7);
		`CHK({setpoint > 0, direction_output}, 2'b11)
		wr(`APM_OFS_CTRL, 32'h9);
		wr(`APM_OFS_TGT, 32'h64);
		go(32'h3);
		`CHK({setpoint > 0, direction_output}, 2'b10)
		wr(`APM_OFS_CTRL, 32'h9);
	endtask
	// jammed axis trips progress check; supervision time zero switches it off
	task automatic t_progress();
		wr(`APM_OFS_CFG, 32'h48);
		uni <= 1'b0;
		stall <= 1'b1;
		go(32'h3);
		wait_idle();
		rd(`APM_OFS_STAT);
		`CHK({rv[6], drive_enable}, 2'b10)
		wr(`APM_OFS_SUPV, 32'h0);
		go(32'h3);
		repeat (60) @(posedge aclk);
		`CHK(drive_enable, 1'b1)
		wr(`APM_OFS_CTRL, 32'h9);
		stall <= 1'b0;
	endtask
	task automatic t_rotary();
		wr(`APM_OFS_CFG, 32'h4a);
		wr(`APM_OFS_ROTEND, 32'h14);
		wr(`APM_OFS_REF, 32'h0);
		wr(`APM_OFS_CTRL, 32'h0);
		wr(`APM_OFS_CTRL, 32'h1);
		wr(`APM_OFS_TGT, 32'hfffffc18);
		go(32'h7);
		repeat (30) @(posedge aclk);
		wr(`APM_OFS_CTRL, 32'h9);
		rd(`APM_OFS_POS);
		`CHK(rv < 20 && rv != 0, 1'b1)
	endtask
	// inverted count during a plus run: rise to fall spans ten falling pulses
	task automatic t_length();
		wr(`APM_OFS_CFG, 32'h34c);
		wr(`APM_OFS_TGT, 32'h3e8);
		go(32'h3);
		meas_in <= 1'b1;
		repeat (30) @(posedge aclk);
		meas_in <= 1'b0;
		repeat (3) @(posedge aclk);
		wr(`APM_OFS_CTRL, 32'h9);
		rd(`APM_OFS_LEN);
		`CHK($signed(rv) >= -11 && $signed(rv) <= -9, 1'b1)
		rd(`APM_OFS_STAT);
		`CHK({rv[9], rv[3]}, 2'b10)
	endtask
	// moving the target away shows a drift; after the clear the check stays off
	task automatic t_window();
		wr(`APM_OFS_CFG, 32'h68);
		wr(`APM_OFS_TGT, 32'h64);
		go(32'h3);
		wait_idle();
		rd(`APM_OFS_STAT);
		`CHK({rv[2], rv[8], ext_error}, 3'b100)
		wr(`APM_OFS_TGT, 32'h1f4);
		rd(`APM_OFS_STAT);
		`CHK({rv[8], ext_error}, 2'b11)
		wr(`APM_OFS_STAT, 32'h100);
		rd(`APM_OFS_STAT);
		`CHK({rv[8], ext_error}, 2'b00)
	endtask
	// reference approach syncs the axis, then the high soft limit stops it
	task automatic t_limits();
		wr(`APM_OFS_CFG, 32'h48);
		wr(`APM_OFS_LOW, 32'hfffffff6);
		wr(`APM_OFS_HIGH, 32'h28);
		wr(`APM_OFS_REF, 32'h14);
		wr(`APM_OFS_TGT, 32'h3e8);
		ref_sw <= 1'b1;
		go(32'h13);
		repeat (6) @(posedge aclk);
		ref_sw <= 1'b0;
		wait_idle();
		rd(`APM_OFS_STAT);
		`CHK({rv[5], rv[1], rv[0]}, 3'b110)
		rd(`APM_OFS_POS);
		`CHK($signed(rv) >= 41 && $signed(rv) <= 42, 1'b1)
		wr(`APM_OFS_CTRL, 32'h0);
		wr(`APM_OFS_CTRL, 32'h1);
		rd(`APM_OFS_STAT);
		`CHK({rv[1], rv[0]}, 2'b00)
		rd(`APM_OFS_POS);
		`CHK(rv, 32'h14)
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_defaults();
		t_bipolar();
		t_unipolar();
		t_progress();
		t_length();
		t_window();
		t_rotary();
		t_limits();
		report_and_stop();
	end
	// hang guard, far beyond the few thousand cycles the scenarios need
	initial begin
		repeat (40000) @(posedge aclk);
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
